// ---- logic/xcvr_ctl_pkg.sv ----
// constants and carriers of the transceiver transmit control and status block
`default_nettype none
package xcvr_ctl_pkg;
    localparam logic [7:0] DIAG_DEV_ADDR   = 8'hA2;
    localparam logic [7:0] STATUS_BYTE     = 8'h6E;
    localparam int         FAULT_BIT       = 2;
    localparam int         LOST_BIT        = 1;
    localparam int         SOFT_OFF_BIT    = 6;
    localparam logic       SOFT_OFF_RESET  = 1'b0;
    localparam logic       LATCH_RESET     = 1'b0;
    localparam logic [7:0] BYTE_RESET      = 8'h00;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] dev;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mgmt_req_t;

    typedef struct packed {
        logic       dis_prev;
        logic       fault_latch;
        logic       soft_off;
        logic       laser_on;
        logic       tx_fault;
        logic       sig_lost;
        logic [7:0] rdata;
        logic       rvalid;
    } ctl_state_t;
endpackage
`default_nettype wire

// ---- logic/xcvr_tx_ctl.sv ----
// transmit disable, transmit fault and receive loss logic with management byte access
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RULE_01: disable pin high forces laser off
// RULE_02: management write also turns transmitter off, readable
// RULE_03: disable pin toggle resets faulted transmitter
// RULE_04: laser fault or low supply: fault, laser off
// RULE_05: fault output low normal, high on fault
// RULE_06: laser fault latches; cleared by toggle, reset
// RULE_07: low supply fault follows supply, no latch
// RULE_08: fault reported byte 110 bit 2
// RULE_09: fault raised only by hardware conditions
// RULE_10: signal lost high when optical power low
// RULE_11: signal lost reported byte 110 bit 1
// RULE_12: diagnostic bytes 0..255 at device A2
// RULE_13: status byte tracks live output levels
module xcvr_tx_ctl (
    input  wire logic                      MCLK,
    input  wire logic                      SYS_RST,
    input  wire logic                      TX_DISABLE,
    input  wire logic                      LASER_FAULT,
    input  wire logic                      SUPPLY_LOW,
    input  wire logic                      RX_POWER_LOW,
    input  wire xcvr_ctl_pkg::mgmt_req_t   MGMT_REQ,
    output logic                           LASER_ON,
    output logic                           TX_FAULT,
    output logic                           RECEIVE_SIGNAL_LOST,
    output logic                           SOFT_TX_OFF,
    output logic [7:0]                     MGMT_RDATA,
    output logic                           MGMT_RVALID
);

    xcvr_ctl_pkg::ctl_state_t state_reg;
    xcvr_ctl_pkg::ctl_state_t state_next;
    logic                     toggle_seen;
    logic                     diag_hit;
    logic                     status_hit;
    logic [7:0]               status_byte;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        state_next  = state_reg;
        // rising edge of the pin starts the toggle that clears a trip
        toggle_seen = TX_DISABLE && !state_reg.dis_prev;                              // RULE_03
        diag_hit    = (MGMT_REQ.dev == xcvr_ctl_pkg::DIAG_DEV_ADDR);                  // RULE_12
        status_hit  = diag_hit && (MGMT_REQ.addr == xcvr_ctl_pkg::STATUS_BYTE);
        status_byte = xcvr_ctl_pkg::BYTE_RESET;
        // live levels, not a snapshot
        status_byte[xcvr_ctl_pkg::FAULT_BIT]    = state_reg.tx_fault;                 // RULE_08 RULE_13
        status_byte[xcvr_ctl_pkg::LOST_BIT]     = state_reg.sig_lost;                 // RULE_11 RULE_13
        status_byte[xcvr_ctl_pkg::SOFT_OFF_BIT] = state_reg.soft_off;                 // RULE_02

        state_next.dis_prev = TX_DISABLE;
        // set wins over clear: a fault in the clearing cycle stays latched
        if (LASER_FAULT) begin
            state_next.fault_latch = 1'b1;                                            // RULE_06
        end else if (toggle_seen) begin
            state_next.fault_latch = 1'b0;                                            // RULE_06
        end

        if (MGMT_REQ.wr && status_hit) begin
            state_next.soft_off = MGMT_REQ.wdata[xcvr_ctl_pkg::SOFT_OFF_BIT];         // RULE_02
        end

        // soft disable is deliberately not a fault source
        state_next.tx_fault = LASER_FAULT || state_next.fault_latch || SUPPLY_LOW;    // RULE_04 RULE_07 RULE_09
        state_next.laser_on = !(TX_DISABLE || state_next.soft_off
                                || state_next.tx_fault);                              // RULE_01 RULE_04
        state_next.sig_lost = RX_POWER_LOW;                                           // RULE_10

        // other devices on the two-wire bus are served elsewhere
        state_next.rvalid = MGMT_REQ.rd && diag_hit;                                  // RULE_12
        state_next.rdata  = xcvr_ctl_pkg::BYTE_RESET;
        if (MGMT_REQ.rd && status_hit) begin
            state_next.rdata = status_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; reset doubles as power cycle

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_reg.dis_prev    <= 1'b0;
            state_reg.fault_latch <= xcvr_ctl_pkg::LATCH_RESET;
            state_reg.soft_off    <= xcvr_ctl_pkg::SOFT_OFF_RESET;
            state_reg.laser_on    <= 1'b0;
            state_reg.tx_fault    <= 1'b0;
            state_reg.sig_lost    <= 1'b0;
            state_reg.rdata       <= xcvr_ctl_pkg::BYTE_RESET;
            state_reg.rvalid      <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign LASER_ON            = state_reg.laser_on;
    assign TX_FAULT            = state_reg.tx_fault;
    assign RECEIVE_SIGNAL_LOST = state_reg.sig_lost;
    assign SOFT_TX_OFF         = state_reg.soft_off;
    assign MGMT_RDATA          = state_reg.rdata;
    assign MGMT_RVALID         = state_reg.rvalid;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_pin_laser_off: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE_01
        TX_DISABLE |=> !LASER_ON)
        else $error("laser on one cycle after disable pin high");

    a_soft_laser_off: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE_02
        (MGMT_REQ.wr && MGMT_REQ.dev == 8'hA2 && MGMT_REQ.addr == 8'h6E && MGMT_REQ.wdata[6])
        |=> SOFT_TX_OFF && !LASER_ON)
        else $error("soft disable write did not turn laser off");

    a_toggle_clears: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE_03
        (TX_DISABLE && !$past(TX_DISABLE) && !LASER_FAULT && !SUPPLY_LOW)
        |=> !TX_FAULT)
        else $error("disable toggle did not clear fault");

    a_fault_kills_laser: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE_04
        (LASER_FAULT || SUPPLY_LOW) |=> TX_FAULT && !LASER_ON)
        else $error("fault did not raise flag and stop laser");

    a_normal_no_fault: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE_05
        LASER_ON |-> !TX_FAULT)
        else $error("fault flag high while laser running");

    a_fault_held: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE_06
        (LASER_FAULT ##1 (!TX_DISABLE && !LASER_FAULT)[*3]) |=> TX_FAULT)
        else $error("laser fault latch lost without toggle");

    a_supply_follows: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE_07
        (SUPPLY_LOW ##1 !SUPPLY_LOW && !LASER_FAULT && !state_reg.fault_latch) |=> !TX_FAULT)
        else $error("low supply fault was latched");

    a_status_fault: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE_08
        (MGMT_REQ.rd && MGMT_REQ.dev == 8'hA2 && MGMT_REQ.addr == 8'h6E)
        |=> MGMT_RVALID && MGMT_RDATA[2] == $past(TX_FAULT))
        else $error("status byte fault bit wrong");

    a_soft_no_fault: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE_09
        (!LASER_FAULT && !SUPPLY_LOW && !state_reg.fault_latch) |=> !TX_FAULT)
        else $error("fault flag raised without hardware cause");

    a_lost_follows: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE_10
        ##1 RECEIVE_SIGNAL_LOST == $past(RX_POWER_LOW))
        else $error("signal lost output does not track optical power");

    a_status_lost: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE_11
        (MGMT_REQ.rd && MGMT_REQ.dev == 8'hA2 && MGMT_REQ.addr == 8'h6E)
        |=> MGMT_RDATA[1] == $past(RECEIVE_SIGNAL_LOST))
        else $error("status byte lost bit wrong");

    a_other_dev_quiet: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE_12
        (MGMT_REQ.rd && MGMT_REQ.dev != 8'hA2) |=> !MGMT_RVALID)
        else $error("answered a foreign device address");

    ////////////////////////////////////////////////////////////////////////////
    // checks on the clearing race, spare bits, silent requests and reset

    a_set_wins: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE_06
        (LASER_FAULT && TX_DISABLE && !$past(TX_DISABLE)) ##1 (!LASER_FAULT && !TX_DISABLE)
        |=> TX_FAULT)
        else $error("fault arriving with the toggle was cleared");

    a_laser_runs: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE_01
        (!TX_DISABLE && !LASER_FAULT && !SUPPLY_LOW && !TX_FAULT && !SOFT_TX_OFF && !MGMT_REQ.wr)
        |=> LASER_ON)
        else $error("laser held off with no cause");

    a_supply_no_latch: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE_07
        (SUPPLY_LOW && !LASER_FAULT && !TX_FAULT) ##1 (!SUPPLY_LOW && !LASER_FAULT)
        |=> !TX_FAULT)
        else $error("fault flag stayed high after supply recovered");

    a_soft_release: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE_02
        (MGMT_REQ.wr && MGMT_REQ.dev == xcvr_ctl_pkg::DIAG_DEV_ADDR
         && MGMT_REQ.addr == xcvr_ctl_pkg::STATUS_BYTE && !MGMT_REQ.wdata[xcvr_ctl_pkg::SOFT_OFF_BIT])
        |=> !SOFT_TX_OFF)
        else $error("soft disable not released by write");

    a_foreign_write: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE_12
        (MGMT_REQ.wr && MGMT_REQ.dev != xcvr_ctl_pkg::DIAG_DEV_ADDR)
        |=> SOFT_TX_OFF == $past(SOFT_TX_OFF))
        else $error("write to a foreign device changed soft disable");

    a_status_soft: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE_02
        (MGMT_REQ.rd && MGMT_REQ.dev == xcvr_ctl_pkg::DIAG_DEV_ADDR
         && MGMT_REQ.addr == xcvr_ctl_pkg::STATUS_BYTE)
        |=> MGMT_RDATA[xcvr_ctl_pkg::SOFT_OFF_BIT] == $past(SOFT_TX_OFF))
        else $error("status byte soft disable bit wrong");

    a_status_spare: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE_13
        (MGMT_REQ.rd && MGMT_REQ.dev == xcvr_ctl_pkg::DIAG_DEV_ADDR
         && MGMT_REQ.addr == xcvr_ctl_pkg::STATUS_BYTE)
        |=> (MGMT_RDATA & 8'hB9) == 8'h00)
        else $error("status byte spare bits not zero");

    a_other_byte_zero: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE_12
        (MGMT_REQ.rd && MGMT_REQ.dev == xcvr_ctl_pkg::DIAG_DEV_ADDR
         && MGMT_REQ.addr != xcvr_ctl_pkg::STATUS_BYTE)
        |=> MGMT_RVALID && MGMT_RDATA == xcvr_ctl_pkg::BYTE_RESET)
        else $error("unmapped diagnostic byte not read as zero");

    a_idle_no_answer: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE_12
        !(MGMT_REQ.rd && MGMT_REQ.dev == xcvr_ctl_pkg::DIAG_DEV_ADDR) |=> !MGMT_RVALID)
        else $error("read answer without a read request");

    a_reset_quiet: assert property (@(posedge MCLK) // RULE_06
        SYS_RST |-> !LASER_ON && !TX_FAULT && !SOFT_TX_OFF && !MGMT_RVALID)
        else $error("outputs active while reset held");

    a_lost_no_fault: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE_09
        (RX_POWER_LOW && !LASER_FAULT && !SUPPLY_LOW && !TX_FAULT) |=> !TX_FAULT)
        else $error("signal loss raised the fault flag");

endmodule
`default_nettype wire

// ---- test/host_model.sv ----
// host board model: transmit-off pin and management byte requests
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input  wire logic                   MCLK,
    input  wire logic [7:0]             MGMT_RDATA,
    input  wire logic                   MGMT_RVALID,
    output var  logic                   TX_DISABLE,
    output var  xcvr_ctl_pkg::mgmt_req_t MGMT_REQ
);
    initial begin
        TX_DISABLE = 1'b0;
        MGMT_REQ = '0;
    end
    // pin level set off the sampling edge; a toggle is two calls
    task automatic pin(input logic v);
        @(negedge MCLK) TX_DISABLE = v;
    endtask
    // one-cycle request; idle fields inverted so stale values cannot pass
    task automatic access(input logic w, input logic [7:0] dev, input logic [7:0] adr,
                          input logic [7:0] wd, output logic [7:0] rd, output logic vld);
        @(negedge MCLK);
        MGMT_REQ = '{rd: ~w, wr: w, dev: dev, addr: adr, wdata: wd};
        @(negedge MCLK);
        vld = MGMT_RVALID;
        rd = MGMT_RDATA;
        MGMT_REQ = '{rd: 1'b0, wr: 1'b0, dev: ~dev, addr: ~adr, wdata: ~wd};
    endtask
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench of the transmit control and status block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    logic                    MCLK, SYS_RST, TX_DISABLE, LASER_FAULT, SUPPLY_LOW, RX_POWER_LOW;
    logic                    LASER_ON, TX_FAULT, RECEIVE_SIGNAL_LOST, SOFT_TX_OFF, MGMT_RVALID;
    logic [7:0]              MGMT_RDATA, d;
    logic                    v;
    xcvr_ctl_pkg::mgmt_req_t MGMT_REQ;
    int                      n_mismatch = 0, comparisons = 0, cycles = 0;
    xcvr_tx_ctl dut_u (.MCLK(MCLK), .SYS_RST(SYS_RST), .TX_DISABLE(TX_DISABLE), .LASER_FAULT(LASER_FAULT),
        .SUPPLY_LOW(SUPPLY_LOW), .RX_POWER_LOW(RX_POWER_LOW), .MGMT_REQ(MGMT_REQ), .LASER_ON(LASER_ON),
        .TX_FAULT(TX_FAULT), .RECEIVE_SIGNAL_LOST(RECEIVE_SIGNAL_LOST), .SOFT_TX_OFF(SOFT_TX_OFF),
        .MGMT_RDATA(MGMT_RDATA), .MGMT_RVALID(MGMT_RVALID));
    host_model host_u (.MCLK(MCLK), .MGMT_RDATA(MGMT_RDATA), .MGMT_RVALID(MGMT_RVALID),
        .TX_DISABLE(TX_DISABLE), .MGMT_REQ(MGMT_REQ));
    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end
    task automatic finish_test();
        $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////
    // outputs {laser, fault, lost, soft} one edge later
    task automatic out_chk(input logic [3:0] e);
        @(negedge MCLK) `CHK({LASER_ON, TX_FAULT, RECEIVE_SIGNAL_LOST, SOFT_TX_OFF}, e)
    endtask
    task automatic rd_chk(input logic [7:0] dev, input logic [7:0] a, input logic [7:0] e, input logic ev);
        host_u.access(1'b0, dev, a, 8'h00, d, v);
        `CHK(v, ev)
        `CHK(d, e)
    endtask
    task automatic t_pin();
        host_u.pin(1'b1);
        out_chk(4'h0);
        host_u.pin(1'b0);
        out_chk(4'h8);
    endtask
    task automatic t_latch();
        @(negedge MCLK) LASER_FAULT = 1'b1;
        out_chk(4'h4);
        LASER_FAULT = 1'b0;
        out_chk(4'h4);
        rd_chk(8'hA2, 8'h6E, 8'h04, 1'b1);
        host_u.pin(1'b1);
        host_u.pin(1'b0);
        out_chk(4'h8);
        LASER_FAULT = 1'b1;
        @(negedge MCLK) LASER_FAULT = 1'b0;
        SYS_RST = 1'b1;
        @(negedge MCLK) `CHK(TX_FAULT, 1'b0)
        SYS_RST = 1'b0;
        out_chk(4'h8);
    endtask
    task automatic t_supply_los();
        SUPPLY_LOW = 1'b1;
        out_chk(4'h4);
        SUPPLY_LOW = 1'b0;
        RX_POWER_LOW = 1'b1;
        out_chk(4'hA);
        rd_chk(8'hA2, 8'h6E, 8'h02, 1'b1);
        RX_POWER_LOW = 1'b0;
        out_chk(4'h8);
        rd_chk(8'hA2, 8'h6E, 8'h00, 1'b1);
    endtask
    task automatic t_soft();
        host_u.access(1'b1, 8'hA2, 8'h6E, 8'hFF, d, v);
        `CHK(v, 1'b0)
        out_chk(4'h1);
        rd_chk(8'hA2, 8'h6E, 8'h40, 1'b1);
        host_u.access(1'b1, 8'hA0, 8'h6E, 8'h00, d, v);
        out_chk(4'h1);
        rd_chk(8'hA2, 8'h00, 8'h00, 1'b1);
        rd_chk(8'hA0, 8'h6E, 8'h00, 1'b0);
        host_u.access(1'b1, 8'hA2, 8'h6E, 8'h00, d, v);
        out_chk(4'h8);
    endtask
    // fault in the very cycle the pin rises: set must beat clear
    task automatic t_set_wins();
        host_u.pin(1'b1);
        LASER_FAULT = 1'b1;
        host_u.pin(1'b0);
        LASER_FAULT = 1'b0;
        out_chk(4'h4);
        host_u.pin(1'b1);
        host_u.pin(1'b0);
        out_chk(4'h8);
    endtask
    initial begin
        {SYS_RST, LASER_FAULT, SUPPLY_LOW, RX_POWER_LOW} = 4'h8;
        repeat (4) @(negedge MCLK);
        SYS_RST = 1'b0;
        t_pin();
        t_latch();
        t_supply_los();
        t_soft();
        t_set_wins();
        finish_test();
    end
endmodule
`default_nettype wire
